//--- hw/pasl_pkg.sv
// Package of constants for the PHY address strap latch
// Operation
// (R1) Five strap pins select one of 32 addresses
// (R2) All-zero captured address enters isolated condition
// (R3) Strap pin n latched into control bit n
// (R4) Shared LED/strap pin read as address bit
// (R5) Reset input initializes or reinitializes device
// (R6) Reset restores register defaults and resamples straps
// (R7) Isolation keeps management register access working
// (R8) LED drive held off until capture completes
package pasl_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int APB_AW = 12;
  // Register word index and byte offsets
  localparam logic [11:0] PHY_CONTROL_IDX = 12'h019;
  localparam logic [11:0] PHY_CONTROL_OFS = {PHY_CONTROL_IDX[9:0], 2'b00};
  localparam logic [11:0] LAMP_CTRL_OFS = 12'h100;
  localparam logic [11:0] STATUS_OFS = 12'h104;
  // phy_control field layout
  localparam int ADDR_LSB = 0;
  localparam int CTRL_W = 16;
  localparam logic [15:0] PHY_CONTROL_RST = 16'h0000;
  localparam logic [15:0] PHY_CONTROL_WMASK = 16'hffe0;
  // Status fields
  localparam int ST_ISOLATE = 0;
  localparam int ST_DONE = 1;
  // Strap settle time before capture, in ns
  localparam int SETTLE_NS = 300;
  localparam int CLK_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);
  typedef enum logic [2:0] {
    PASL_SETTLE = 3'b001,
    PASL_CAPTURE = 3'b010,
    PASL_RUN = 3'b100
  } pasl_state_t;
endpackage

//--- hw/pasl_strap_latch.sv
// PHY address strap latch with APB register access
`timescale 1ns/1ps
`default_nettype none
module pasl_strap_latch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pasl_pkg::APB_AW-1:0] paddr_i,
  input wire logic [pasl_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [pasl_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [pasl_pkg::ADDR_W-1:0] lamp_on_i,
  input wire logic [pasl_pkg::ADDR_W-1:0] addr_strap_i,
  output logic [pasl_pkg::ADDR_W-1:0] addr_strap_o,
  output logic [pasl_pkg::ADDR_W-1:0] addr_strap_oe_n_o,
  output logic [pasl_pkg::ADDR_W-1:0] phy_addr_o,
  output logic isolate_o,
  output logic capture_done_o
);
  import pasl_pkg::*;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  pasl_state_t state_r;
  pasl_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic settled;
  logic capturing;
  logic done;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [ADDR_W-1:0] lamp_en_r;
  logic [ADDR_W-1:0] lamp_en_nxt;
  logic [ADDR_W-1:0] lamp_out_r;
  logic [ADDR_W-1:0] lamp_out_nxt;
  logic [ADDR_W-1:0] lamp_oe_n_r;
  logic [ADDR_W-1:0] lamp_oe_n_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // ----------------------------------------
  // Bus signals
  // ----------------------------------------
  logic access;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic sel_ctrl;
  logic sel_lamp;
  logic sel_status;
  logic addr_zero;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Full-word address match
  function automatic logic is_reg(
    input logic [APB_AW-1:0] addr,
    input logic [APB_AW-1:0] ofs
  );
    logic match;
    match = (addr == ofs);
    return match;
  endfunction

  // Byte lanes 0 and 1 onto a 16-bit value
  function automatic logic [CTRL_W-1:0] merge16(
    input logic [CTRL_W-1:0] old_v,
    input logic [DATA_W-1:0] wd,
    input logic [3:0] st
  );
    logic [CTRL_W-1:0] v;
    v = old_v;
    if (st[0]) begin
      v[7:0] = wd[7:0];
    end
    if (st[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  // Software write keeps the captured address bits
  function automatic logic [CTRL_W-1:0] ctrl_write(
    input logic [CTRL_W-1:0] old_v,
    input logic [DATA_W-1:0] wd,
    input logic [3:0] st
  );
    logic [CTRL_W-1:0] v;
    v = merge16(old_v, wd, st);
    v = (old_v & ~PHY_CONTROL_WMASK) | (v & PHY_CONTROL_WMASK);
    return v;
  endfunction

  // Status word: capture done and isolate flags
  function automatic logic [DATA_W-1:0] status_word(
    input logic fin,
    input logic iso
  );
    logic [DATA_W-1:0] w;
    w = '0;
    w[ST_DONE] = fin;
    w[ST_ISOLATE] = iso;
    return w;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign access = psel_i && penable_i;
  assign wr_en = access && pwrite_i;
  assign rd_en = access && !pwrite_i;
  assign sel_ctrl = is_reg(paddr_i, PHY_CONTROL_OFS);
  assign sel_lamp = is_reg(paddr_i, LAMP_CTRL_OFS);
  assign sel_status = is_reg(paddr_i, STATUS_OFS);
  assign hit = sel_ctrl || sel_lamp || sel_status;

  // ----------------------------------------
  // Capture sequencer
  // ----------------------------------------
  // Straps are read only once their levels have settled
  assign settled = (cnt_r == SETTLE_CNT);
  assign capturing = (state_r == PASL_CAPTURE);
  assign done = (state_r == PASL_RUN);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      PASL_SETTLE: begin
        // Pins released while straps settle
        if (settled) begin
          state_nxt = PASL_CAPTURE;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      PASL_CAPTURE: begin
        // One cycle to latch the strap levels
        state_nxt = PASL_RUN;
      end
      PASL_RUN: begin
        // Stays here until the next reset
        state_nxt = PASL_RUN;
      end
      default: begin
        state_nxt = PASL_SETTLE;
        cnt_nxt = 4'h0;
      end
    endcase
    if (rst_i) begin // (R5) (R6)
      state_nxt = PASL_SETTLE;
      cnt_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    state_r <= state_nxt;
    cnt_r <= cnt_nxt;
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Writes before capture are dropped so capture always wins
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (capturing) begin
      // Strap level n into bit n
      for (int n = 0; n < ADDR_W; n++) begin
        ctrl_nxt[ADDR_LSB + n] = addr_strap_i[n]; // (R3) (R4) (R1)
      end
    end else if (done && wr_en && sel_ctrl) begin // (R7)
      // Registers stay reachable in isolation
      ctrl_nxt = ctrl_write(ctrl_r, pwdata_i, pstrb_i);
    end
    if (rst_i) begin // (R6)
      ctrl_nxt = PHY_CONTROL_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    ctrl_r <= ctrl_nxt;
  end

  // ----------------------------------------
  // Lamp enable register
  // ----------------------------------------
  // Cleared by reset so straps are released for the next capture
  always_comb begin
    lamp_en_nxt = lamp_en_r;
    if (done && wr_en && sel_lamp && pstrb_i[0]) begin
      lamp_en_nxt = pwdata_i[ADDR_W-1:0];
    end
    if (rst_i) begin // (R6)
      lamp_en_nxt = 5'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    lamp_en_r <= lamp_en_nxt;
  end

  // ----------------------------------------
  // Lamp pin drive
  // ----------------------------------------
  // Registered, so a pin never drives while its strap is sampled
  always_comb begin
    lamp_out_nxt = 5'h00;
    lamp_oe_n_nxt = 5'h1f;
    for (int n = 0; n < ADDR_W; n++) begin
      if (done && lamp_en_r[n]) begin // (R8)
        lamp_out_nxt[n] = lamp_on_i[n];
        lamp_oe_n_nxt[n] = 1'b0;
      end
    end
    if (rst_i) begin // (R6)
      lamp_out_nxt = 5'h00;
      lamp_oe_n_nxt = 5'h1f;
    end
  end

  always_ff @(posedge clk_i) begin
    lamp_out_r <= lamp_out_nxt;
    lamp_oe_n_r <= lamp_oe_n_nxt;
  end

  assign addr_strap_o = lamp_out_r;
  assign addr_strap_oe_n_o = lamp_oe_n_r;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Holds the last word outside read accesses
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      if (sel_ctrl) begin
        rdata_nxt = {16'h0000, ctrl_r};
      end else if (sel_lamp) begin
        rdata_nxt = {27'h0000000, lamp_en_r};
      end else if (sel_status) begin
        rdata_nxt = status_word(done, isolate_o);
      end else begin
        rdata_nxt = '0;
      end
    end
    if (rst_i) begin
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_r <= rdata_nxt;
  end

  // ----------------------------------------
  // Bus outputs
  // ----------------------------------------
  // No wait states: every access ends in its first cycle
  assign pready_o = 1'b1;

  always_comb begin
    pslverr_o = 1'b0;
    if (access && !hit) begin
      // Unmapped offsets report an error and change nothing
      pslverr_o = 1'b1;
    end
  end

  always_comb begin
    prdata_o = rdata_r;
    if (rd_en) begin
      // Read data stands during the access cycle
      prdata_o = rdata_nxt;
    end
  end

  // ----------------------------------------
  // Address and isolation outputs
  // ----------------------------------------
  assign phy_addr_o = ctrl_r[ADDR_LSB +: ADDR_W];
  assign addr_zero = (phy_addr_o == 5'h00);
  assign capture_done_o = done;

  always_comb begin
    isolate_o = 1'b0;
    if (done && addr_zero) begin // (R2)
      // All-zero address isolates, bus access unaffected
      isolate_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verif/pasl_chk.sv
// Port assertions for the strap latch
`timescale 1ns/1ps
`default_nettype none
module pasl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic [4:0] addr_strap_i,
  input wire logic [4:0] addr_strap_oe_n_o,
  input wire logic [4:0] phy_addr_o,
  input wire logic isolate_o,
  input wire logic capture_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_state:
    assert property ($fell(rst_i) |-> &addr_strap_oe_n_o && !capture_done_o
      && !isolate_o) else $error("not reset");
  chk_done_soon:
    assert property ($fell(rst_i) |-> ##[1:8] capture_done_o) else $error("late");
  chk_done_kept:
    assert property (capture_done_o |=> capture_done_o) else $error("done lost");
  chk_addr_hold:
    assert property (capture_done_o |=> $stable(phy_addr_o)) else $error("addr");
  chk_addr_capture:
    assert property ($rose(capture_done_o) |-> phy_addr_o == addr_strap_i)
      else $error("capture");
  chk_isolate_zero:
    assert property ($rose(capture_done_o) |->
      isolate_o == (addr_strap_i == 5'h00)) else $error("isolate");
  chk_lamp_gate:
    assert property (!capture_done_o |-> &addr_strap_oe_n_o) else $error("lamp");
  chk_mgmt_isolated:
    assert property (isolate_o && psel_i && penable_i && !pwrite_i
      && paddr_i == pasl_pkg::PHY_CONTROL_OFS |->
      !pslverr_o && prdata_o[4:0] == phy_addr_o) else $error("mgmt");
endmodule
bind pasl_strap_latch pasl_chk i_pasl_chk (.*);
`default_nettype wire

//--- verif/pasl_strap_latch_bench.sv
// Bench for the strap latch
`timescale 1ns/1ps
`default_nettype none
module pasl_strap_latch_bench;
  import pasl_pkg::*;
  logic clk_i=0, rst_i=1, psel_i=0, penable_i=0, pwrite_i=0, e;
  logic pready_o, pslverr_o, isolate_o, capture_done_o;
  logic [11:0] paddr_i=12'h000;
  logic [31:0] pwdata_i=32'h0, prdata_o, q;
  logic [3:0] pstrb_i=4'hf;
  logic [4:0] lamp_on_i=5'h00, strap_i=5'h00, addr_strap_i, addr_strap_o;
  logic [4:0] addr_strap_oe_n_o, phy_addr_o;
  logic [4:0] vals[7]='{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f};
  int miscompares=0, checked=0;
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin miscompares++; \
  $display("[FAIL] %0t mismatch", $time); end end
  initial forever #50 clk_i = ~clk_i;
  pasl_strap_model i_pasl_strap_model (
    .strap_i(strap_i),
    .addr_strap_o(addr_strap_o),
    .addr_strap_oe_n_o(addr_strap_oe_n_o),
    .addr_strap_i(addr_strap_i)
  );
  pasl_strap_latch i_pasl_strap_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .lamp_on_i(lamp_on_i),
    .addr_strap_i(addr_strap_i),
    .addr_strap_o(addr_strap_o),
    .addr_strap_oe_n_o(addr_strap_oe_n_o),
    .phy_addr_o(phy_addr_o),
    .isolate_o(isolate_o),
    .capture_done_o(capture_done_o)
  );
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i) penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    q = prdata_o; e = pslverr_o; psel_i <= 1'b0; penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task boot(input logic [4:0] a);
    @(posedge clk_i);
    strap_i <= a;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 20 && capture_done_o !== 1'b1; i++) @(posedge clk_i);
    `CHK(capture_done_o, 1'b1)
    `CHK(addr_strap_oe_n_o, 5'h1f)
  endtask
  task t_capture;
    foreach (vals[i]) begin
      boot(vals[i]);
      `CHK(phy_addr_o, vals[i])
      `CHK(isolate_o, vals[i] == 5'h00)
      apb(1'b0, PHY_CONTROL_OFS, 32'h0);
      `CHK(q, {27'h0, vals[i]})
    end
    $display("t_capture over");
  endtask
  task t_rewrite;
    boot(5'h0a);
    apb(1'b1, PHY_CONTROL_OFS, 32'hffffffff);
    apb(1'b0, PHY_CONTROL_OFS, 32'h0);
    `CHK(q, 32'h0000ffea)
    apb(1'b1, LAMP_CTRL_OFS, 32'h1f);
    lamp_on_i <= 5'h15;
    apb(1'b0, 12'h200, 32'h0);
    `CHK(addr_strap_i, 5'h15)
    `CHK(e, 1'b1)
    boot(5'h0a);
    apb(1'b0, PHY_CONTROL_OFS, 32'h0);
    `CHK(q, 32'h0000000a)
    $display("t_rewrite over");
  endtask
  task t_early;
    @(posedge clk_i);
    strap_i <= 5'h13;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b1, PHY_CONTROL_OFS, 32'h0000ff00);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(q, 32'h00000000)
    for (int i = 0; i < 20 && capture_done_o !== 1'b1; i++) @(posedge clk_i);
    apb(1'b0, PHY_CONTROL_OFS, 32'h0);
    `CHK(q, 32'h00000013)
    pstrb_i <= 4'h2;
    apb(1'b1, PHY_CONTROL_OFS, 32'hffffffff);
    pstrb_i <= 4'hf;
    apb(1'b0, PHY_CONTROL_OFS, 32'h0);
    `CHK(q, 32'h0000ff13)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(q, 32'h00000002)
    $display("t_early over");
  endtask
  task stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    stop_test;
  end
  initial begin
    t_capture;
    t_rewrite;
    t_early;
    stop_test;
  end
endmodule
`default_nettype wire

//--- verif/pasl_strap_model.sv
// Strap resistors and shared lamp pins
`timescale 1ns/1ps
`default_nettype none
module pasl_strap_model (
  input wire logic [4:0] strap_i,
  input wire logic [4:0] addr_strap_o,
  input wire logic [4:0] addr_strap_oe_n_o,
  output logic [4:0] addr_strap_i
);
  // Resistor level when released
  assign addr_strap_i = (addr_strap_oe_n_o & strap_i) |
    (~addr_strap_oe_n_o & addr_strap_o);
endmodule
`default_nettype wire
